// File: include/lesm_defs.vh
// Register indices, field positions, reset values and bus codes for the lane error monitor
`ifndef LESM_DEFS_VH
`define LESM_DEFS_VH

// ==========================================================
// Register indices (byte address is four times the index)
`define LESM_IDX_W          12
`define LESM_IDX_LINK_PAGE  12'h300
`define LESM_IDX_DESKEW     12'h46c
`define LESM_IDX_DISP       12'h46d
`define LESM_IDX_INVALID    12'h46e
`define LESM_IDX_THRESH     12'h470
`define LESM_IDX_IRQ_STAT   12'h480
`define LESM_IDX_IRQ_MASK   12'h481
`define LESM_IDX_CNT_CLR    12'h482

// ==========================================================
// Field positions
`define LESM_BIT_ALIGN0     0
`define LESM_BIT_CNT_CLR    0
`define LESM_IRQ_DISP       0
`define LESM_IRQ_INVALID    1
`define LESM_IRQ_ALIGN_LOST 2
`define LESM_IRQ_W          3

// ==========================================================
// Reset values
`define LESM_FLAG_RST       8'h00
`define LESM_THRESH_RST     8'hff
`define LESM_PAGE_RST       8'h00
`define LESM_IRQ_RST        3'h0

// ==========================================================
// Bus answers
`define LESM_RESP_OKAY      2'h0
`define LESM_RESP_SLVERR    2'h2

`endif

// File: verilog/lesm_err_counter.v
// Saturating per-lane error counter with threshold flag
module lesm_err_counter #(
    parameter CNT_W = 8
) (
    // Clock and reset
    input  wire             ref_clk,
    input  wire             rst,
    // Control
    input  wire             clear,
    input  wire             err_evt,
    input  wire [CNT_W-1:0] threshold,
    // Status
    output reg              flag
);

    reg [CNT_W-1:0] count;
    wire            count_full = &count;

    // ==========================================================
    // Counter
    // Saturates so a noisy lane never wraps back under threshold
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            count <= {CNT_W{1'b0}};
            flag  <= 1'b0;
        end else begin
            if (clear) begin
                count <= {CNT_W{1'b0}};
            end else if (err_evt && !count_full) begin
                count <= count + {{(CNT_W-1){1'b0}}, 1'b1};
            end
            flag <= !clear && (count >= threshold);
        end
    end

endmodule

// File: verilog/lesm_top.v
// Lane error status monitor: counters, paged status registers, AXI4-Lite slave
//
// Notes on behaviour
// - Lane 0 alignment result read-only: 0 failed, 1 achieved.
// - Eight read-only disparity fault flags, bit n is lane n.
// - Invalid-code flags for lane 7 at bit 7, lane 6 at bit 6.
// - Flag is 0 while count below threshold, 1 at or above it.
// - Status banked per link, link chosen by page field at 0x300.
// - All status flags reset to 0 and are read-only.
`include "lesm_defs.vh"

module lesm_top #(
    parameter NUM_LINKS = 2,
    parameter PAGE_W    = 1,
    parameter CNT_W     = 8
) (
    // Clock and reset
    input  wire                   ref_clk,
    input  wire                   rst,
    // Lane events from the receive datapath
    input  wire [NUM_LINKS*8-1:0] disp_err_evt,
    input  wire [NUM_LINKS*2-1:0] invalid_code_evt,
    input  wire [NUM_LINKS-1:0]   align_lane0_in,
    // AXI4-Lite write address
    input  wire                   s_axi_awvalid,
    output reg                    s_axi_awready,
    input  wire [31:0]            s_axi_awaddr,
    input  wire [2:0]             s_axi_awprot,
    // AXI4-Lite write data
    input  wire                   s_axi_wvalid,
    output reg                    s_axi_wready,
    input  wire [31:0]            s_axi_wdata,
    input  wire [3:0]             s_axi_wstrb,
    // AXI4-Lite write response
    output reg                    s_axi_bvalid,
    input  wire                   s_axi_bready,
    output reg  [1:0]             s_axi_bresp,
    // AXI4-Lite read address
    input  wire                   s_axi_arvalid,
    output reg                    s_axi_arready,
    input  wire [31:0]            s_axi_araddr,
    input  wire [2:0]             s_axi_arprot,
    // AXI4-Lite read data
    output reg                    s_axi_rvalid,
    input  wire                   s_axi_rready,
    output reg  [31:0]            s_axi_rdata,
    output reg  [1:0]             s_axi_rresp,
    // Interrupt
    output reg                    irq
);

    // ==========================================================
    // Control and interrupt status registers
    reg  [PAGE_W-1:0]        link_page;
    reg  [CNT_W-1:0]         error_count_threshold;
    reg                      cnt_clear;
    reg  [`LESM_IRQ_W-1:0]   irq_status;
    reg  [`LESM_IRQ_W-1:0]   irq_mask;

    // ==========================================================
    // Per-link status
    wire [NUM_LINKS*8-1:0]   disp_flag;
    wire [NUM_LINKS*2-1:0]   invalid_flag;
    reg  [NUM_LINKS-1:0]     lane0_alignment_done;
    reg  [NUM_LINKS*8-1:0]   disp_flag_q;
    reg  [NUM_LINKS*2-1:0]   invalid_flag_q;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_LINKS * 8; gi = gi + 1) begin : g_disp
            lesm_err_counter #(
                .CNT_W     (CNT_W)
            ) u_disp (
                .ref_clk   (ref_clk),
                .rst       (rst),
                .clear     (cnt_clear),
                .err_evt   (disp_err_evt[gi]),
                .threshold (error_count_threshold),
                .flag      (disp_flag[gi])
            );
        end
        for (gi = 0; gi < NUM_LINKS * 2; gi = gi + 1) begin : g_invalid
            lesm_err_counter #(
                .CNT_W     (CNT_W)
            ) u_invalid (
                .ref_clk   (ref_clk),
                .rst       (rst),
                .clear     (cnt_clear),
                .err_evt   (invalid_code_evt[gi]),
                .threshold (error_count_threshold),
                .flag      (invalid_flag[gi])
            );
        end
    endgenerate

    // Alignment result and previous flag values captured per link
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            lane0_alignment_done <= {NUM_LINKS{1'b0}};
            disp_flag_q          <= {(NUM_LINKS*8){1'b0}};
            invalid_flag_q       <= {(NUM_LINKS*2){1'b0}};
        end else begin
            lane0_alignment_done <= align_lane0_in;
            disp_flag_q          <= disp_flag;
            invalid_flag_q       <= invalid_flag;
        end
    end

    // ==========================================================
    // Interrupt events
    wire [`LESM_IRQ_W-1:0] irq_event;

    assign irq_event[`LESM_IRQ_DISP]       = |(disp_flag & ~disp_flag_q);
    assign irq_event[`LESM_IRQ_INVALID]    = |(invalid_flag & ~invalid_flag_q);
    assign irq_event[`LESM_IRQ_ALIGN_LOST] = |(~align_lane0_in & lane0_alignment_done);

    // ==========================================================
    // Paged read view
    wire                  page_ok = (link_page < NUM_LINKS);
    reg  [7:0]            sel_disp;
    reg  [7:0]            sel_invalid;
    reg                   sel_align;
    integer               li;

    always @* begin
        sel_disp    = `LESM_FLAG_RST;
        sel_invalid = `LESM_FLAG_RST;
        sel_align   = 1'b0;
        for (li = 0; li < NUM_LINKS; li = li + 1) begin
            if (page_ok && (link_page == li)) begin
                sel_disp         = disp_flag[li*8 +: 8];
                sel_invalid[7]   = invalid_flag[li*2+1];
                sel_invalid[6]   = invalid_flag[li*2];
                sel_align        = lane0_alignment_done[li];
            end
        end
    end

    // ==========================================================
    // Read decode
    wire [`LESM_IDX_W-1:0] rd_idx = s_axi_araddr[`LESM_IDX_W+1:2];
    reg  [31:0]            rd_value;
    reg                    rd_hit;

    always @* begin
        rd_value = 32'h0000_0000;
        rd_hit   = 1'b1;
        case (rd_idx)
            `LESM_IDX_LINK_PAGE: begin
                rd_value[PAGE_W-1:0] = link_page;
            end
            `LESM_IDX_DESKEW: begin
                rd_value[`LESM_BIT_ALIGN0] = sel_align;
            end
            `LESM_IDX_DISP: begin
                rd_value[7:0] = sel_disp;
            end
            `LESM_IDX_INVALID: begin
                rd_value[7:0] = sel_invalid;
            end
            `LESM_IDX_THRESH: begin
                rd_value[CNT_W-1:0] = error_count_threshold;
            end
            `LESM_IDX_IRQ_STAT: begin
                rd_value[`LESM_IRQ_W-1:0] = irq_status;
            end
            `LESM_IDX_IRQ_MASK: begin
                rd_value[`LESM_IRQ_W-1:0] = irq_mask;
            end
            `LESM_IDX_CNT_CLR: begin
                rd_value = 32'h0000_0000;
            end
            default: begin
                rd_hit = 1'b0;
            end
        endcase
    end

    // ==========================================================
    // Read channel
    // One read at a time: arready drops until the data is taken
    wire rd_take = s_axi_arvalid && s_axi_arready;
    wire stat_rd = rd_take && (rd_idx == `LESM_IDX_IRQ_STAT);

    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `LESM_RESP_OKAY;
        end else begin
            if (rd_take) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= rd_value;
                s_axi_rresp   <= rd_hit ? `LESM_RESP_OKAY : `LESM_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // ==========================================================
    // Write channels
    // Address and data accepted in either order, held until both arrive
    reg  [`LESM_IDX_W-1:0] wr_idx;
    reg  [7:0]             wr_byte;
    reg                    wr_lane0;
    reg                    aw_full;
    reg                    w_full;
    wire                   wr_go = aw_full && w_full && !s_axi_bvalid;
    reg                    wr_hit;

    always @* begin
        case (wr_idx)
            `LESM_IDX_LINK_PAGE,
            `LESM_IDX_THRESH,
            `LESM_IDX_IRQ_MASK,
            `LESM_IDX_CNT_CLR,
            `LESM_IDX_DESKEW,
            `LESM_IDX_DISP,
            `LESM_IDX_INVALID,
            `LESM_IDX_IRQ_STAT: begin
                wr_hit = 1'b1;
            end
            default: begin
                wr_hit = 1'b0;
            end
        endcase
    end

    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `LESM_RESP_OKAY;
            aw_full       <= 1'b0;
            w_full        <= 1'b0;
            wr_idx        <= {`LESM_IDX_W{1'b0}};
            wr_byte       <= 8'h00;
            wr_lane0      <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awready <= 1'b0;
                aw_full       <= 1'b1;
                wr_idx        <= s_axi_awaddr[`LESM_IDX_W+1:2];
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wready <= 1'b0;
                w_full       <= 1'b1;
                wr_byte      <= s_axi_wdata[7:0];
                wr_lane0     <= s_axi_wstrb[0];
            end
            if (wr_go) begin
                aw_full      <= 1'b0;
                w_full       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? `LESM_RESP_OKAY : `LESM_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // ==========================================================
    // Register writes
    // Status registers ignore writes; only control fields store
    wire wr_do = wr_go && wr_lane0;

    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            link_page             <= {PAGE_W{1'b0}};
            error_count_threshold <= `LESM_THRESH_RST;
            irq_mask              <= `LESM_IRQ_RST;
            cnt_clear             <= 1'b0;
        end else begin
            cnt_clear <= 1'b0;
            if (wr_do) begin
                case (wr_idx)
                    `LESM_IDX_LINK_PAGE: begin
                        link_page <= wr_byte[PAGE_W-1:0];
                    end
                    `LESM_IDX_THRESH: begin
                        error_count_threshold <= wr_byte[CNT_W-1:0];
                    end
                    `LESM_IDX_IRQ_MASK: begin
                        irq_mask <= wr_byte[`LESM_IRQ_W-1:0];
                    end
                    `LESM_IDX_CNT_CLR: begin
                        cnt_clear <= wr_byte[`LESM_BIT_CNT_CLR];
                    end
                    default: begin
                        cnt_clear <= 1'b0;
                    end
                endcase
            end
        end
    end

    // ==========================================================
    // Interrupt status and output
    // A new event in the clearing read's cycle stays set
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            irq_status <= `LESM_IRQ_RST;
            irq        <= 1'b0;
        end else begin
            if (stat_rd) begin
                irq_status <= irq_event;
            end else begin
                irq_status <= irq_status | irq_event;
            end
            irq <= |(irq_status & irq_mask);
        end
    end

endmodule

// File: dv/lesm_lane_src.sv
// Lane event source standing in for the far-side transmitter
module lesm_lane_src (
    // Clock
    input  wire         ref_clk,
    // Lane events
    output logic [15:0] disp_err_evt,
    output logic [3:0]  invalid_code_evt,
    output logic [1:0]  align_lane0_in
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        disp_err_evt = 16'h0000;
        invalid_code_evt = 4'h0;
        align_lane0_in = 2'h0;
    end

    // ==========================================
    // Separate one-cycle faults, then time to settle
    task automatic pulse(input logic [15:0] d, input logic [3:0] v, input int k);
        for (int i = 0; i < k; i++) begin
            @(posedge ref_clk);
            disp_err_evt <= d;
            invalid_code_evt <= v;
            @(posedge ref_clk);
            disp_err_evt <= 16'h0000;
            invalid_code_evt <= 4'h0;
        end
        repeat (5) @(posedge ref_clk);
    endtask

    task automatic set_align(input logic [1:0] a);
        @(posedge ref_clk);
        align_lane0_in <= a;
        repeat (3) @(posedge ref_clk);
    endtask
endmodule

// File: dv/lesm_checker.sv
// Bus and status read checks for the lane error monitor
`include "lesm_defs.vh"
module lesm_checker (
    // Clock and reset
    input wire        ref_clk,
    input wire        rst,
    // Write side
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire        s_axi_wvalid,
    input wire        s_axi_wready,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire [1:0]  s_axi_bresp,
    // Read side
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire [31:0] s_axi_araddr,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0]  s_axi_rresp,
    // Interrupt
    input wire        irq
);
    timeunit 1ns;
    timeprecision 1ps;

    // ==========================================
    // Index of the read under way
    reg  [11:0] rd_idx;
    wire        rd_map;
    always @(posedge ref_clk or posedge rst)
        if (rst)
            rd_idx <= 12'h000;
        else if (s_axi_arvalid && s_axi_arready)
            rd_idx <= s_axi_araddr[13:2];
    assign rd_map = rd_idx inside {`LESM_IDX_LINK_PAGE, `LESM_IDX_DESKEW, `LESM_IDX_DISP,
        `LESM_IDX_INVALID, `LESM_IDX_THRESH, `LESM_IDX_IRQ_STAT, `LESM_IDX_IRQ_MASK,
        `LESM_IDX_CNT_CLR};

    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);

    // ==========================================
    // Assertions
    chk_reset_idle: assert property ($fell(rst)
        |-> !s_axi_rvalid && !s_axi_bvalid && !irq)
        else $error("bus or irq busy after reset");
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid)
        else $error("read answer late");
    // Address and data are registered first, the response one edge later
    chk_write_answer: assert property (s_axi_awvalid && s_axi_awready
        && s_axi_wvalid && s_axi_wready |=> !s_axi_awready ##1 s_axi_bvalid)
        else $error("write answer late");
    chk_read_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    chk_resp_hold: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    chk_upper_zero: assert property (s_axi_rvalid
        |-> s_axi_rdata[31:8] == 24'h000000)
        else $error("upper read bits set");
    chk_deskew_bits: assert property (s_axi_rvalid && rd_idx == `LESM_IDX_DESKEW
        |-> s_axi_rdata[7:1] == 7'h00)
        else $error("deskew register has extra bits");
    chk_invalid_bits: assert property (s_axi_rvalid && rd_idx == `LESM_IDX_INVALID
        |-> s_axi_rdata[5:0] == 6'h00)
        else $error("invalid code low bits set");
    chk_unmapped_err: assert property (s_axi_rvalid && !rd_map
        |-> s_axi_rresp == `LESM_RESP_SLVERR && s_axi_rdata == 32'h00000000)
        else $error("unmapped read not refused");
endmodule

bind lesm_top lesm_checker chk_u (.ref_clk, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
    .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .irq);

// File: dv/lane_error_status_monitor_tb.sv
// Self-checking bench for the lane error monitor
`include "lesm_defs.vh"
module lane_error_status_monitor_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic ref_clk = 1'b0, rst = 1'b1, irq;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic [1:0] s_axi_bresp, s_axi_rresp, r, align_lane0_in;
    logic [15:0] disp_err_evt;
    logic [3:0] invalid_code_evt;
    logic [31:0] d;
    int mismatches = 0, comparisons = 0;

    initial forever #25 ref_clk = ~ref_clk;

    lesm_lane_src src_u (.ref_clk, .disp_err_evt, .invalid_code_evt, .align_lane0_in);
    lesm_top dut_u (.ref_clk, .rst, .disp_err_evt, .invalid_code_evt, .align_lane0_in,
        .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_awprot, .s_axi_wvalid,
        .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
        .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_arprot, .s_axi_rvalid,
        .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .irq);

    // ==========================================
    // Reporting
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic logic [31:0] ba(input logic [11:0] i);
        return {18'h0, i, 2'b00};
    endfunction

    // ==========================================
    // Bus master; every wait is bounded
    task automatic wr(input logic [11:0] i, input logic [31:0] v);
        int n;
        @(posedge ref_clk);
        s_axi_awvalid <= 1'b1;
        s_axi_awaddr <= ba(i);
        s_axi_wvalid <= 1'b1;
        s_axi_wdata <= v;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge ref_clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        if (n == 40) begin
            mismatches++;
            final_report();
        end
    endtask

    task automatic rd(input logic [11:0] i);
        int n;
        @(posedge ref_clk);
        s_axi_arvalid <= 1'b1;
        s_axi_araddr <= ba(i);
        s_axi_rready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge ref_clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        if (n == 40) begin
            mismatches++;
            final_report();
        end
    endtask

    // ==========================================
    // Scenarios
    task automatic t_reset_ro();
        rd(`LESM_IDX_DISP);
        check(d, 32'h0);
        rd(`LESM_IDX_INVALID);
        check(d, 32'h0);
        rd(`LESM_IDX_DESKEW);
        check(d, 32'h0);
        wr(`LESM_IDX_DISP, 32'hff);
        check({30'h0, r}, {30'h0, `LESM_RESP_OKAY});
        rd(`LESM_IDX_DISP);
        check(d, 32'h0);
    endtask

    task automatic t_thresh();
        wr(`LESM_IDX_THRESH, 32'h3);
        src_u.pulse(16'h00a5, 4'h0, 2);
        rd(`LESM_IDX_DISP);
        check(d, 32'h0);
        src_u.pulse(16'h00ff, 4'h0, 1);
        src_u.pulse(16'h005a, 4'h0, 1);
        rd(`LESM_IDX_DISP);
        check(d, 32'ha5);
        src_u.pulse(16'h005a, 4'h0, 1);
        rd(`LESM_IDX_DISP);
        check(d, 32'hff);
    endtask

    task automatic t_invalid();
        src_u.pulse(16'h0, 4'h2, 3);
        rd(`LESM_IDX_INVALID);
        check(d, 32'h80);
        src_u.pulse(16'h0, 4'h1, 3);
        rd(`LESM_IDX_INVALID);
        check(d, 32'hc0);
    endtask

    task automatic t_page();
        // Link 1 traffic must stay out of sight until its page is chosen
        src_u.pulse(16'h3c00, 4'h0, 3);
        src_u.set_align(2'b10);
        rd(`LESM_IDX_DESKEW);
        check(d, 32'h0);
        rd(`LESM_IDX_DISP);
        check(d, 32'hff);
        wr(`LESM_IDX_LINK_PAGE, 32'h1);
        rd(`LESM_IDX_DISP);
        check(d, 32'h3c);
        rd(`LESM_IDX_INVALID);
        check(d, 32'h0);
        rd(`LESM_IDX_DESKEW);
        check(d, 32'h1);
        wr(`LESM_IDX_LINK_PAGE, 32'h0);
    endtask

    task automatic t_unmapped();
        rd(12'h001);
        check({30'h0, r}, {30'h0, `LESM_RESP_SLVERR});
        check(d, 32'h0);
        wr(12'h001, 32'h1);
        check({30'h0, r}, {30'h0, `LESM_RESP_SLVERR});
    endtask

    task automatic t_irq();
        wr(`LESM_IDX_CNT_CLR, 32'h1);
        rd(`LESM_IDX_DISP);
        check(d, 32'h0);
        // Disparity and invalid-code flags have both risen by now
        rd(`LESM_IDX_IRQ_STAT);
        check(d, 32'h3);
        src_u.pulse(16'h0001, 4'h0, 3);
        check({31'h0, irq}, 32'h0);
        rd(`LESM_IDX_IRQ_STAT);
        check(d, 32'h1);
        wr(`LESM_IDX_IRQ_MASK, 32'h1);
        src_u.pulse(16'h0002, 4'h0, 3);
        check({31'h0, irq}, 32'h1);
        rd(`LESM_IDX_IRQ_STAT);
        check(d, 32'h1);
        repeat (3) @(posedge ref_clk);
        check({31'h0, irq}, 32'h0);
        // Link 1 loses lane 0 alignment
        src_u.set_align(2'b00);
        rd(`LESM_IDX_IRQ_STAT);
        check(d, 32'h4);
    endtask

    task automatic t_reset_mid();
        // Lanes 0 and 1 of link 0 are flagged when this reset hits
        @(posedge ref_clk);
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        rd(`LESM_IDX_DISP);
        check(d, 32'h0);
        rd(`LESM_IDX_THRESH);
        check(d, {24'h0, `LESM_THRESH_RST});
        // A low threshold shows whether the counters were really cleared
        wr(`LESM_IDX_THRESH, 32'h1);
        rd(`LESM_IDX_DISP);
        check(d, 32'h0);
        rd(`LESM_IDX_IRQ_STAT);
        check(d, 32'h0);
        check({31'h0, irq}, 32'h0);
    endtask

    initial begin
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        t_reset_ro();
        t_thresh();
        t_invalid();
        t_page();
        t_unmapped();
        t_irq();
        t_reset_mid();
        final_report();
    end
endmodule
